/* hw/seb_pkg.sv */
package seb_pkg;
    localparam int CLK_MHZ = 125;
    localparam int LINK_PERIOD_NS = 30;
    localparam int SCL_KHZ = 400;
    localparam int QTR_CYC = (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
    localparam int COMMAND_HOLDOFF_TIME_US = 100;
    localparam int HOLDOFF_CYC = COMMAND_HOLDOFF_TIME_US * CLK_MHZ;
    localparam int SPIKE_FILTER_WIDTH_NS = 100;
    localparam int FILT_RAW = (SPIKE_FILTER_WIDTH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
    localparam int BYTE_BITS = 8;
    localparam int ACK_BIT = 8;
    localparam int DIR_BIT = 0;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
    localparam logic SCL_RESET = 1'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        SEB_OP_START = 2'h0,
        SEB_OP_STOP = 2'h1,
        SEB_OP_WRITE = 2'h2,
        SEB_OP_READ = 2'h3
    } seb_op_t;
endpackage

/* hw/seb_if.sv */
`timescale 1ns/1ps
interface seb_if;
    logic scl;
    logic sda;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;

    // Wired-AND with pull-up: any enabled low driver pulls the line down
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

    modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface

/* hw/seb_fifo.sv */
`timescale 1ns/1ps
module seb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = seb_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } seb_fifo_state_t;

    seb_fifo_state_t s;
    seb_fifo_state_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != FULL);
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // seb_fifo

/* hw/seb_dev.sv */
// Contract
// RULE_01: Device is slave; master starts every transfer.
// RULE_02: Sample on SCL rise, change on fall.
// RULE_03: Bytes travel most significant bit first.
// RULE_04: Ninth clock carries acknowledge from receiver.
// RULE_05: Master clocks bytes without pauses.
// RULE_06: Data changes only while SCL low.
// RULE_07: SDA change with SCL high is start/stop.
// RULE_08: Unlimited bytes between start and stop.
// RULE_09: Bus idle only with both lines high.
// RULE_10: Filter short spikes on SCL and SDA.
// RULE_11: Ignore bus until reset released, then standby.
// RULE_12: Master waits holdoff time before first command.
// RULE_13: Start is SDA fall with SCL high.
// RULE_14: Stop is SDA rise, returns to standby.
// RULE_15: Transmitter releases after bit eight; receiver acks.
// RULE_16: Master NACK ends read; device releases SDA.
// RULE_17: Device only pulls SDA low, else released.
`timescale 1ns/1ps
module seb_dev (
    input wire logic LINK_CLK,
    input wire logic RST,
    seb_if.dev BUS,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic BUSY
);
    localparam int FCW = $clog2(seb_pkg::FILT_CYC + 1);
    localparam logic [FCW-1:0] FILT_LAST = FCW'(seb_pkg::FILT_CYC - 1);
    localparam logic [3:0] BITS_DONE = 4'(seb_pkg::BYTE_BITS);

    typedef enum logic [2:0] {
        SEB_ST_STANDBY = 3'h0,
        SEB_ST_RECV = 3'h1,
        SEB_ST_ACK_OUT = 3'h2,
        SEB_ST_SEND = 3'h3,
        SEB_ST_ACK_IN = 3'h4,
        SEB_ST_WAIT = 3'h5
    } seb_dev_st_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic scl_q;
        logic sda_q;
        logic [FCW-1:0] scl_c;
        logic [FCW-1:0] sda_c;
        logic armed;
        seb_dev_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic hdr;
        logic rd;
        logic nack;
        logic oe;
        logic tx_ready;
        logic busy;
        logic push;
    } seb_dev_state_t;

    seb_dev_state_t s;
    seb_dev_state_t next_s;
    logic fifo_in_ready;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] tx_byte;

    // Level must hold for the full filter width before it is believed
    function automatic logic [FCW:0] glitch_filter(input logic s1, input logic s2, input logic f,
                                                   input logic [FCW-1:0] c);
        if (s1 == s2 && s2 != f) begin
            if (c == FILT_LAST) begin
                return {s2, {FCW{1'b0}}};
            end
            return {f, c + 1'b1};
        end
        return {f, {FCW{1'b0}}};
    endfunction

    assign rise = s.scl_f && !s.scl_q;
    assign fall = !s.scl_f && s.scl_q;
    assign start = s.armed && s.scl_f && s.scl_q && s.sda_q && !s.sda_f; // RULE_07 RULE_13
    assign stop = s.armed && s.scl_f && s.scl_q && !s.sda_q && s.sda_f; // RULE_07 RULE_14
    // No back-pressure on reads: an empty source reads as all ones
    assign tx_byte = TX_VALID ? TX_DATA : seb_pkg::IDLE_TX_BYTE;

    always_comb begin
        next_s = s;
        next_s.scl_s = {s.scl_s[1:0], BUS.scl};
        next_s.sda_s = {s.sda_s[1:0], BUS.sda};
        {next_s.scl_f, next_s.scl_c} = glitch_filter(s.scl_s[1], s.scl_s[2], s.scl_f, s.scl_c); // RULE_10
        {next_s.sda_f, next_s.sda_c} = glitch_filter(s.sda_s[1], s.sda_s[2], s.sda_f, s.sda_c); // RULE_10
        next_s.scl_q = s.scl_f;
        next_s.sda_q = s.sda_f;
        next_s.tx_ready = 1'b0;
        next_s.push = 1'b0;
        if (s.scl_f && s.sda_f) begin
            next_s.armed = 1'b1; // RULE_09 RULE_11
        end
        if (start) begin
            next_s.st = SEB_ST_RECV; // RULE_01 RULE_13
            next_s.cnt = seb_pkg::BIT_ZERO;
            next_s.hdr = 1'b1;
            next_s.oe = 1'b0;
            next_s.busy = 1'b1;
        end else if (stop) begin
            next_s.st = SEB_ST_STANDBY; // RULE_14
            next_s.oe = 1'b0;
            next_s.busy = 1'b0;
        end else begin
            unique case (s.st)
                SEB_ST_STANDBY: begin
                    next_s.oe = 1'b0;
                end
                SEB_ST_RECV: begin
                    if (rise && s.cnt != BITS_DONE) begin
                        next_s.sh = {s.sh[6:0], s.sda_f}; // RULE_02 RULE_03
                        next_s.cnt = s.cnt + 1'b1; // RULE_08
                    end else if (fall && s.cnt == BITS_DONE) begin
                        if (s.hdr) begin
                            next_s.rd = s.sh[seb_pkg::DIR_BIT];
                            next_s.oe = 1'b1; // RULE_04 RULE_15
                        end else begin
                            // Full buffer answers NACK; the bus cannot be stalled
                            next_s.oe = fifo_in_ready; // RULE_04 RULE_15
                            next_s.push = fifo_in_ready;
                        end
                        next_s.st = SEB_ST_ACK_OUT;
                    end
                end
                SEB_ST_ACK_OUT: begin
                    if (fall) begin
                        next_s.oe = 1'b0; // RULE_15
                        next_s.cnt = seb_pkg::BIT_ZERO;
                        next_s.hdr = 1'b0;
                        if (s.rd) begin
                            next_s.sh = tx_byte;
                            next_s.tx_ready = TX_VALID;
                            next_s.oe = !tx_byte[7]; // RULE_02 RULE_06 RULE_17
                            next_s.st = SEB_ST_SEND;
                        end else begin
                            next_s.st = SEB_ST_RECV;
                        end
                    end
                end
                SEB_ST_SEND: begin
                    if (rise) begin
                        next_s.cnt = s.cnt + 1'b1;
                    end else if (fall) begin
                        if (s.cnt == BITS_DONE) begin
                            next_s.oe = 1'b0; // RULE_15
                            next_s.st = SEB_ST_ACK_IN;
                        end else begin
                            next_s.sh = {s.sh[6:0], 1'b0}; // RULE_03
                            next_s.oe = !s.sh[6]; // RULE_02 RULE_06 RULE_17
                        end
                    end
                end
                SEB_ST_ACK_IN: begin
                    if (rise) begin
                        next_s.nack = s.sda_f; // RULE_04
                    end else if (fall) begin
                        next_s.cnt = seb_pkg::BIT_ZERO;
                        if (s.nack) begin
                            next_s.st = SEB_ST_WAIT; // RULE_16
                        end else begin
                            next_s.sh = tx_byte;
                            next_s.tx_ready = TX_VALID;
                            next_s.oe = !tx_byte[7]; // RULE_02 RULE_17
                            next_s.st = SEB_ST_SEND;
                        end
                    end
                end
                SEB_ST_WAIT: begin
                    next_s.oe = 1'b0; // RULE_16 RULE_17
                end
                default: begin
                    next_s.st = SEB_ST_STANDBY;
                    next_s.oe = 1'b0;
                end
            endcase
        end
    end

    // Filtered levels reset low so the bus must be seen idle first
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            s <= '0; // RULE_11
        end else begin
            s <= next_s;
        end
    end

    seb_fifo #(
        .W(8),
        .DEPTH(seb_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(LINK_CLK),
        .rst(RST),
        .in_valid(s.push),
        .in_ready(fifo_in_ready),
        .in_data(s.sh),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_DATA)
    );

    assign BUS.sda_dev_o = 1'b0; // RULE_17
    assign BUS.sda_dev_oe = s.oe;
    assign TX_READY = s.tx_ready;
    assign BUSY = s.busy;
endmodule // seb_dev

/* hw/seb_host.sv */
`timescale 1ns/1ps
module seb_host #(
    parameter int HOLDOFF_CYC = seb_pkg::HOLDOFF_CYC,
    parameter int QTR_CYC = seb_pkg::QTR_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    seb_if.host BUS,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire seb_pkg::seb_op_t CMD_OP,
    input wire logic [7:0] CMD_DATA,
    input wire logic CMD_LAST,
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    output logic RSP_NACK
);
    localparam int HW = $clog2(HOLDOFF_CYC + 1);
    localparam int QW = $clog2(QTR_CYC + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLDOFF_CYC - 1);
    localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYC - 1);
    localparam logic [3:0] ACK_IDX = 4'(seb_pkg::ACK_BIT);

    typedef enum logic [1:0] {
        SEB_HST_HOLD = 2'h0,
        SEB_HST_IDLE = 2'h1,
        SEB_HST_RUN = 2'h2
    } seb_host_st_t;

    typedef struct packed {
        seb_host_st_t st;
        logic [HW-1:0] hold;
        logic [QW-1:0] q;
        logic [1:0] ph;
        logic [3:0] bitn;
        seb_pkg::seb_op_t op;
        logic [7:0] sh;
        logic last;
        logic scl;
        logic oe;
        logic [2:0] sda_s;
        logic sda_f;
        logic rdy;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_nack;
    } seb_host_state_t;

    seb_host_state_t s;
    seb_host_state_t next_s;

    // Returns {scl, oe} for the phase being entered
    function automatic logic [1:0] drive(input seb_pkg::seb_op_t op, input logic [1:0] ph,
                                         input logic [3:0] bitn, input logic b7, input logic last,
                                         input logic cur_oe);
        logic o;
        o = cur_oe;
        unique case (op)
            seb_pkg::SEB_OP_START: begin
                return {ph == 2'h1 || ph == 2'h2, ph[1]}; // RULE_13
            end
            seb_pkg::SEB_OP_STOP: begin
                return {ph != 2'h0, !ph[1]}; // RULE_14
            end
            seb_pkg::SEB_OP_WRITE, seb_pkg::SEB_OP_READ: begin
                // Data moves only at phase 0, a full quarter after SCL fell
                if (ph == 2'h0) begin
                    if (bitn == ACK_IDX) begin
                        o = (op == seb_pkg::SEB_OP_READ) && !last; // RULE_04 RULE_15 RULE_16
                    end else begin
                        o = (op == seb_pkg::SEB_OP_WRITE) && !b7; // RULE_03 RULE_06
                    end
                end
                return {ph == 2'h1 || ph == 2'h2, o};
            end
        endcase
    endfunction

    always_comb begin
        next_s = s;
        next_s.sda_s = {s.sda_s[1:0], BUS.sda};
        if (s.sda_s[1] == s.sda_s[2]) begin
            next_s.sda_f = s.sda_s[2];
        end
        next_s.rsp_valid = 1'b0;
        unique case (s.st)
            SEB_HST_HOLD: begin
                if (s.hold == HOLD_LAST) begin
                    next_s.st = SEB_HST_IDLE; // RULE_12
                    next_s.rdy = 1'b1;
                end else begin
                    next_s.hold = s.hold + 1'b1;
                end
            end
            SEB_HST_IDLE: begin
                if (CMD_VALID) begin
                    next_s.op = CMD_OP; // RULE_01
                    next_s.sh = CMD_DATA;
                    next_s.last = CMD_LAST;
                    next_s.bitn = seb_pkg::BIT_ZERO;
                    next_s.ph = 2'h0;
                    next_s.q = '0;
                    next_s.rdy = 1'b0;
                    next_s.st = SEB_HST_RUN;
                    {next_s.scl, next_s.oe} = drive(CMD_OP, 2'h0, seb_pkg::BIT_ZERO, CMD_DATA[7], CMD_LAST, s.oe);
                end
            end
            SEB_HST_RUN: begin
                if (s.q != QTR_LAST) begin
                    next_s.q = s.q + 1'b1;
                end else begin
                    next_s.q = '0;
                    if (s.ph == 2'h2 && s.op[1]) begin
                        if (s.bitn == ACK_IDX) begin
                            next_s.rsp_nack = s.sda_f; // RULE_04
                        end else begin
                            next_s.sh = {s.sh[6:0], s.sda_f}; // RULE_03
                        end
                    end
                    if (s.ph == 2'h3 && s.op[1] && s.bitn != ACK_IDX) begin
                        next_s.bitn = s.bitn + 1'b1; // RULE_05
                        next_s.ph = 2'h0;
                    end else if (s.ph == 2'h3) begin
                        next_s.st = SEB_HST_IDLE;
                        next_s.rdy = 1'b1;
                        next_s.rsp_valid = 1'b1;
                        next_s.rsp_data = s.sh;
                    end else begin
                        next_s.ph = s.ph + 1'b1;
                    end
                    if (next_s.st == SEB_HST_RUN) begin
                        {next_s.scl, next_s.oe} = drive(s.op, next_s.ph, next_s.bitn, next_s.sh[7], s.last,
                                                        s.oe); // RULE_06
                    end
                end
            end
            default: begin
                next_s.st = SEB_HST_IDLE;
                next_s.rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.scl <= seb_pkg::SCL_RESET;
            s.sda_s <= 3'h7;
            s.sda_f <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign BUS.scl = s.scl;
    assign BUS.sda_host_o = 1'b0;
    assign BUS.sda_host_oe = s.oe;
    assign CMD_READY = s.rdy;
    assign RSP_VALID = s.rsp_valid;
    assign RSP_DATA = s.rsp_data;
    assign RSP_NACK = s.rsp_nack;
endmodule // seb_host

/* dv/seb_props.sv */
`timescale 1ns/1ps
module seb_props #(
    parameter int QTR_CYC = seb_pkg::QTR_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe
);
    logic scl_q;
    logic sda_q;
    logic rst_q;
    logic in_frame;
    logic start_seen;
    logic stop_seen;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic [15:0] rise_cnt;
    assign start_seen = scl && scl_q && sda_q && !sda;
    assign stop_seen = scl && scl_q && !sda_q && sda;
    // High and low counts saturate, since idle stretches may outlast the counters
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            rst_q <= 1'h1;
            in_frame <= 1'h0;
            hi_cnt <= 16'h0;
            lo_cnt <= 16'h0;
            rise_cnt <= 16'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            rst_q <= 1'h0;
            in_frame <= start_seen ? 1'h1 : (stop_seen ? 1'h0 : in_frame);
            hi_cnt <= !scl ? 16'h0 : ((hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h1);
            lo_cnt <= scl ? 16'h0 : ((lo_cnt == 16'hFFFF) ? lo_cnt : lo_cnt + 16'h1);
            rise_cnt <= start_seen ? 16'h0 : rise_cnt + 16'(scl && !scl_q);
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_open_drain: assert property (!sda_host_o && !sda_dev_o)
        else $error("open-drain output driven high");
    a_reset_idle: assert property (rst_q |-> scl && !sda_host_oe)
        else $error("bus not idle after reset");
    a_dev_stable_high: assert property (scl && scl_q |-> $stable(sda_dev_oe))
        else $error("device changed data while clock high");
    a_host_change_slot: assert property (scl && scl_q && $changed(sda_host_oe) |->
        hi_cnt inside {[QTR_CYC - 2:QTR_CYC + 1]}) else $error("host data change outside start or stop slot");
    a_low_time: assert property ($rose(scl) |-> lo_cnt inside {[QTR_CYC - 2:QTR_CYC + 1],
        [2 * QTR_CYC - 2:2 * QTR_CYC + 1]}) else $error("clock low phase has wrong length");
    a_nine_clocks: assert property (stop_seen |-> (rise_cnt % 16'h9) == 16'h1)
        else $error("frame is not whole nine-clock bytes");
    a_idle_released: assert property (!in_frame |-> !sda_dev_oe)
        else $error("device pulls data outside a frame");
    a_bus_idle: assert property (stop_seen |=> (scl && sda) [*8])
        else $error("bus not idle after stop");
    c_start: cover property (start_seen);
    c_stop: cover property (stop_seen);
    c_dev_drive: cover property (scl && sda_dev_oe);
endmodule // seb_props

/* dv/test_serial_eeprom_bus_bit_layer.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            $display("Error %s expected %0h seen %0h", n, e, g); \
            num_errors++; \
        end \
    end
module test_serial_eeprom_bus_bit_layer;
    localparam int HOLD = 50;
    // Short quarter keeps the run brief but leaves the device time to answer
    localparam int QTR = 40;
    localparam seb_pkg::seb_op_t op_start = seb_pkg::SEB_OP_START;
    localparam seb_pkg::seb_op_t op_stop = seb_pkg::SEB_OP_STOP;
    localparam seb_pkg::seb_op_t op_wr = seb_pkg::SEB_OP_WRITE;
    localparam seb_pkg::seb_op_t op_rd = seb_pkg::SEB_OP_READ;
    typedef struct packed {
        seb_pkg::seb_op_t op;
        logic [7:0] d;
        logic last;
        logic [7:0] exp_data;
        logic exp_nack;
        logic exp_busy;
    } seb_row_t;
    seb_row_t rows [9] = '{'{op_start, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1}, '{op_wr, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1},
        '{op_wr, 8'hA5, 1'h0, 8'hA5, 1'h0, 1'h1}, '{op_wr, 8'h3C, 1'h0, 8'h3C, 1'h0, 1'h1},
        '{op_start, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1}, '{op_wr, 8'h01, 1'h0, 8'h01, 1'h0, 1'h1},
        '{op_rd, 8'h00, 1'h0, 8'h96, 1'h0, 1'h1}, '{op_rd, 8'h00, 1'h1, 8'h69, 1'h1, 1'h1},
        '{op_stop, 8'h00, 1'h0, 8'h00, 1'h0, 1'h0}};
    logic clk = 1'h0;
    logic link_clk = 1'h0;
    logic rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_ready;
    seb_pkg::seb_op_t cmd_op = op_start;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_last = 1'h0;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ready = 1'h0;
    logic [7:0] tx_data = 8'h96;
    logic tx_valid = 1'h0;
    logic tx_ready;
    logic busy;
    logic busy2;
    logic s2_oe = 1'h0;
    logic [8:0] wire_sh = 9'h000;
    int tx_idx = 0;
    int lat;
    int n;
    int num_errors = 0;
    int check_count = 0;
    seb_if bus();
    seb_if bus2();
    assign bus2.scl = 1'h1;
    assign bus2.sda_host_o = 1'h0;
    assign bus2.sda_host_oe = s2_oe;
    seb_host #(.HOLDOFF_CYC(HOLD), .QTR_CYC(QTR)) i_seb_host (.CLK(clk), .RST(rst), .BUS(bus),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack));
    seb_dev i_seb_dev (.LINK_CLK(link_clk), .RST(rst), .BUS(bus), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .BUSY(busy));
    seb_dev i_seb_dev_b (.LINK_CLK(link_clk), .RST(rst), .BUS(bus2), .RX_DATA(), .RX_VALID(),
        .RX_READY(1'h0), .TX_DATA(8'hFF), .TX_VALID(1'h0), .TX_READY(), .BUSY(busy2));
    seb_props #(.QTR_CYC(QTR)) i_seb_props (.CLK(clk), .RST(rst), .scl(bus.scl), .sda(bus.sda),
        .sda_host_o(bus.sda_host_o), .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
        .sda_dev_oe(bus.sda_dev_oe));
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    always @(posedge bus.scl) begin
        wire_sh <= {wire_sh[7:0], bus.sda};
    end
    always @(negedge link_clk) begin
        if (tx_ready === 1'h1) begin
            tx_idx = tx_idx + 1;
        end
        tx_valid = (tx_idx < 2);
        tx_data = (tx_idx == 0) ? 8'h96 : 8'h69;
    end
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang(input int k, input int lim);
        if (k > lim) begin
            $display("Error wait expected handshake seen none");
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic do_cmd(input seb_pkg::seb_op_t op, input logic [7:0] d, input logic last);
        int k;
        k = 0;
        // Back to back in the response cycle, so no idle clock is added between bytes
        if (rsp_valid !== 1'h1) begin
            @(negedge clk);
        end
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_data = d;
        cmd_last = last;
        while (cmd_ready !== 1'h1) begin
            k++;
            hang(k, 20000);
            @(negedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'h0;
        lat = 1;
        while (rsp_valid !== 1'h1) begin
            @(negedge clk);
            lat++;
            hang(lat, 4000);
        end
    endtask
    task automatic drain(input logic [7:0] e);
        @(negedge link_clk);
        `CHK("rx_valid", 1'h1, rx_valid)
        `CHK("rx_data", e, rx_data)
        rx_ready = 1'h1;
        @(negedge link_clk);
        rx_ready = 1'h0;
    endtask
    task automatic do_reset;
        @(negedge clk);
        rst = 1'h1;
        repeat (4) @(negedge link_clk);
        `CHK("rst_scl", 1'h1, bus.scl)
        `CHK("rst_ready", 1'h0, cmd_ready)
        `CHK("rst_busy", 1'h0, busy)
        `CHK("rst_rx", 1'h0, rx_valid)
        `CHK("rst_oe", 1'h0, bus.sda_dev_oe)
        @(negedge clk);
        rst = 1'h0;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        `CHK("holdoff", 1'h1, (n >= HOLD) && (n < 1000))
    endtask
    initial begin
        do_reset();
        for (int r = 0; r < 9; r++) begin
            do_cmd(rows[r].op, rows[r].d, rows[r].last);
            `CHK("latency", (rows[r].op[1] ? 36 : 4) * QTR + 1, lat)
            `CHK("busy", rows[r].exp_busy, busy)
            if (rows[r].op[1]) begin
                `CHK("rsp_data", rows[r].exp_data, rsp_data)
                `CHK("rsp_nack", rows[r].exp_nack, rsp_nack)
                `CHK("wire_bits", {rows[r].exp_data, rows[r].exp_nack}, wire_sh)
            end
        end
        `CHK("tx_taken", 2, tx_idx)
        drain(8'hA5);
        drain(8'h3C);
        // Sink stalls: sixteen bytes fill the buffer, the seventeenth is refused
        do_cmd(op_start, 8'h00, 1'h0);
        do_cmd(op_wr, 8'h00, 1'h0);
        for (int i = 0; i < 17; i++) begin
            do_cmd(op_wr, 8'(i), 1'h0);
            `CHK("fill_nack", (i == 16), rsp_nack)
        end
        do_cmd(op_stop, 8'h00, 1'h0);
        for (int i = 0; i < 16; i++) begin
            drain(8'(i));
        end
        @(negedge link_clk);
        `CHK("rx_empty", 1'h0, rx_valid)
        do_reset();
        repeat (7) s2_oe = @(negedge clk) 1'h1;
        @(negedge clk);
        s2_oe = 1'h0;
        repeat (40) @(negedge clk);
        `CHK("spike_busy", 1'h0, busy2)
        s2_oe = 1'h1;
        repeat (60) @(negedge clk);
        `CHK("start_busy", 1'h1, busy2)
        s2_oe = 1'h0;
        repeat (60) @(negedge clk);
        `CHK("stop_busy", 1'h0, busy2)
        wrap_up();
    end
endmodule // test_serial_eeprom_bus_bit_layer
